/* File: pkg/dtr_pkg.sv */
// Constants shared by the trace register block and its bus-side controller
package dtr_pkg;
   // Register indexes on the device port
   localparam logic [3:0] IDX_FORCED_RESET_REQUEST = 4'h0;
   localparam logic [3:0] IDX_COMPARATOR_A_HIGH_BYTE = 4'h1;
   localparam logic [3:0] IDX_COMPARATOR_A_LOW_BYTE = 4'h2;
   localparam logic [3:0] IDX_COMPARATOR_B_HIGH_BYTE = 4'h3;
   localparam logic [3:0] IDX_COMPARATOR_B_LOW_BYTE = 4'h4;
   localparam logic [3:0] IDX_TRACE_FIFO_HIGH_BYTE = 4'h5;
   localparam logic [3:0] IDX_TRACE_FIFO_LOW_BYTE = 4'h6;
   localparam logic [3:0] IDX_TRACE_CONTROL = 4'h7;
   // Control and reset register fields
   localparam int TRACE_UNIT_ENABLE_BIT = 7;
   localparam int CAPTURE_RUN_BIT = 6;
   localparam int BREAK_TAG_SELECT_BIT = 5;
   localparam int BREAK_REQUEST_ENABLE_BIT = 4;
   localparam int COMPARATOR_A_DIRECTION_BIT = 3;
   localparam int COMPARATOR_A_DIRECTION_ENABLE_BIT = 2;
   localparam int COMPARATOR_B_DIRECTION_BIT = 1;
   localparam int COMPARATOR_B_DIRECTION_ENABLE_BIT = 0;
   localparam int FORCE_RESET_BIT = 0;
   // Reset values
   localparam logic [7:0] COMPARATOR_RESET = 8'h00;
   localparam logic [7:0] TRACE_CONTROL_RESET = 8'h00;
   localparam logic [7:0] FORCED_RESET_READ = 8'h00;
   // FIFO shape
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_WIDTH = 16;
   // Controller registers on the Avalon side (byte addresses)
   localparam logic [3:0] AV_COMMAND = 4'h0;
   localparam logic [3:0] AV_STATUS = 4'h4;
   localparam int CMD_INDEX_LSB = 8;
   localparam int CMD_WRITE_BIT = 12;
   localparam int CMD_BACKGROUND_BIT = 13;
   localparam int STATUS_BUSY_BIT = 8;
   // Controller states, Gray coded from DTR_IDLE through DTR_ISSUE to DTR_WAIT
   typedef enum logic [1:0] {
      DTR_IDLE = 2'b00,
      DTR_ISSUE = 2'b01,
      DTR_WAIT = 2'b11
   } dtr_host_state_t;
endpackage

/* File: pkg/dtr_if.sv */
// Register port between the bus controller and the trace register block
`timescale 1ns/1ns
interface dtr_if;
   logic [3:0] reg_index;
   logic [7:0] reg_wdata;
   logic reg_write;
   logic reg_read;
   logic background_path;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   modport device (
      input reg_index,
      input reg_wdata,
      input reg_write,
      input reg_read,
      input background_path,
      output reg_rdata,
      output reg_rvalid
   );
   modport host (
      output reg_index,
      output reg_wdata,
      output reg_write,
      output reg_read,
      output background_path,
      input reg_rdata,
      input reg_rvalid
   );
endinterface

/* File: rtl/dtr_device.sv */
// Trace register block: comparators, trace FIFO, control and forced reset
`timescale 1ns/1ns
module dtr_device #(
   parameter int DEPTH = dtr_pkg::FIFO_DEPTH,
   parameter int WIDTH = dtr_pkg::FIFO_WIDTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Register port
   dtr_if.device bus,
   // CPU taps
   input wire logic cpu_cycle,
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_read,
   input wire logic cpu_fetch,
   input wire logic [7:0] cpu_data,
   // Trigger settings held outside the block
   input wire logic trig_event_only,
   input wire logic trig_begin,
   input wire logic execution_qualify_select,
   input wire logic secure,
   // Results
   output logic break_req,
   output logic break_tag,
   output logic mcu_reset_req,
   output logic capture_run_flag
);
   logic [7:0] ctl_q;
   logic [7:0] ctl_d;
   logic [7:0] cah_q;
   logic [7:0] cal_q;
   logic [7:0] cbh_q;
   logic [7:0] cbl_q;
   logic [WIDTH-1:0] fifo_q [DEPTH];
   logic [3:0] cnt_q;
   logic trig_seen_q;
   logic [15:0] last_fetch_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic break_q;
   logic reset_q;
   logic enable;
   logic arm;
   logic ctl_wr;
   logic cmp_wr;
   logic fl_rd;
   logic a_m;
   logic b_m;
   logic trig;
   logic begin_eff;
   logic store;
   logic [WIDTH-1:0] store_word;
   logic full_reach;
   logic run_done;
   logic arm_start;

   // Address and direction match of one comparator
   function automatic logic cmp_match(input logic [15:0] addr, input logic [15:0] val,
                                      input logic rd, input logic dir_en, input logic dir);
      cmp_match = (addr == val) && (!dir_en || (rd == dir));
   endfunction

   // Enable bit as it would be written, refused while secure
   function automatic logic enable_next(input logic [7:0] w);
      enable_next = w[dtr_pkg::TRACE_UNIT_ENABLE_BIT] && !secure;
   endfunction

   assign enable = ctl_q[dtr_pkg::TRACE_UNIT_ENABLE_BIT];
   assign arm = ctl_q[dtr_pkg::CAPTURE_RUN_BIT] & enable;
   assign ctl_wr = bus.reg_write && bus.reg_index == dtr_pkg::IDX_TRACE_CONTROL;
   assign cmp_wr = bus.reg_write && !arm;
   assign fl_rd = bus.reg_read && bus.reg_index == dtr_pkg::IDX_TRACE_FIFO_LOW_BYTE;

   // Comparator matches on live bus cycles of an armed run
   assign a_m = arm && cpu_cycle && cmp_match(cpu_addr, {cah_q, cal_q}, cpu_read,
      ctl_q[dtr_pkg::COMPARATOR_A_DIRECTION_ENABLE_BIT],
      ctl_q[dtr_pkg::COMPARATOR_A_DIRECTION_BIT]);
   assign b_m = arm && cpu_cycle && cmp_match(cpu_addr, {cbh_q, cbl_q}, cpu_read,
      ctl_q[dtr_pkg::COMPARATOR_B_DIRECTION_ENABLE_BIT],
      ctl_q[dtr_pkg::COMPARATOR_B_DIRECTION_BIT]);
   assign trig = !trig_event_only && (a_m || b_m)
      && (!execution_qualify_select || cpu_fetch);
   assign begin_eff = trig_begin || trig_event_only;

   // What enters the FIFO during a run
   always_comb
   begin
      store = 1'b0;
      store_word = {cpu_addr[15:8], cpu_addr[7:0]};
      if (trig_event_only)
      begin
         store = b_m;
         store_word = {8'h00, cpu_data};
      end
      else if (begin_eff)
      begin
         store = arm && cpu_cycle && cpu_fetch && (trig_seen_q || trig);
      end
      else
      begin
         store = arm && cpu_cycle && cpu_fetch;
      end
   end

   assign full_reach = arm && begin_eff && store && cnt_q == 4'(DEPTH - 1);
   assign run_done = arm && ((!begin_eff && trig) || full_reach);
   assign arm_start = ctl_wr && !arm && enable_next(bus.reg_wdata)
      && bus.reg_wdata[dtr_pkg::CAPTURE_RUN_BIT];

   // Control register next value
   always_comb
   begin
      ctl_d = ctl_q;
      if (ctl_wr)
      begin
         ctl_d = bus.reg_wdata;
         ctl_d[dtr_pkg::TRACE_UNIT_ENABLE_BIT] = enable_next(bus.reg_wdata);
         ctl_d[dtr_pkg::CAPTURE_RUN_BIT] = bus.reg_wdata[dtr_pkg::CAPTURE_RUN_BIT]
            && enable_next(bus.reg_wdata);
      end
      else if (run_done)
      begin
         ctl_d[dtr_pkg::CAPTURE_RUN_BIT] = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         ctl_q <= dtr_pkg::TRACE_CONTROL_RESET;
      else
         ctl_q <= ctl_d;
   end

   // Comparator byte registers
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         cah_q <= dtr_pkg::COMPARATOR_RESET;
         cal_q <= dtr_pkg::COMPARATOR_RESET;
         cbh_q <= dtr_pkg::COMPARATOR_RESET;
         cbl_q <= dtr_pkg::COMPARATOR_RESET;
      end
      else if (cmp_wr)
      begin
         case (bus.reg_index)
            dtr_pkg::IDX_COMPARATOR_A_HIGH_BYTE: cah_q <= bus.reg_wdata;
            dtr_pkg::IDX_COMPARATOR_A_LOW_BYTE: cal_q <= bus.reg_wdata;
            dtr_pkg::IDX_COMPARATOR_B_HIGH_BYTE: cbh_q <= bus.reg_wdata;
            dtr_pkg::IDX_COMPARATOR_B_LOW_BYTE: cbl_q <= bus.reg_wdata;
            default: ;
         endcase
      end
   end

   // Address of the latest opcode fetch
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         last_fetch_q <= 16'h0000;
      else if (cpu_cycle && cpu_fetch)
         last_fetch_q <= cpu_addr;
   end

   // Trigger seen and valid count of the run
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         trig_seen_q <= 1'b0;
         cnt_q <= 4'h0;
      end
      else if (arm_start)
      begin
         trig_seen_q <= 1'b0;
         cnt_q <= 4'h0;
      end
      else
      begin
         if (trig)
            trig_seen_q <= 1'b1;
         if (store && cnt_q != 4'(DEPTH))
            cnt_q <= cnt_q + 4'h1;
      end
   end

   // Shift FIFO: entry 0 is oldest and faces the ports
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < DEPTH; i++)
            fifo_q[i] <= '0;
      end
      else if (store || (fl_rd && !arm))
      begin
         for (int i = 0; i < DEPTH - 1; i++)
            fifo_q[i] <= fifo_q[i + 1];
         fifo_q[DEPTH - 1] <= store ? store_word : last_fetch_q;
      end
   end

   // Read data, one cycle after the read strobe
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= bus.reg_read;
         if (bus.reg_read)
         begin
            case (bus.reg_index)
               dtr_pkg::IDX_FORCED_RESET_REQUEST: rdata_q <= dtr_pkg::FORCED_RESET_READ;
               dtr_pkg::IDX_COMPARATOR_A_HIGH_BYTE: rdata_q <= cah_q;
               dtr_pkg::IDX_COMPARATOR_A_LOW_BYTE: rdata_q <= cal_q;
               dtr_pkg::IDX_COMPARATOR_B_HIGH_BYTE: rdata_q <= cbh_q;
               dtr_pkg::IDX_COMPARATOR_B_LOW_BYTE: rdata_q <= cbl_q;
               dtr_pkg::IDX_TRACE_FIFO_HIGH_BYTE:
                  rdata_q <= trig_event_only ? 8'h00 : fifo_q[0][15:8];
               dtr_pkg::IDX_TRACE_FIFO_LOW_BYTE: rdata_q <= fifo_q[0][7:0];
               dtr_pkg::IDX_TRACE_CONTROL: rdata_q <= ctl_q;
               default: rdata_q <= 8'h00;
            endcase
         end
      end
   end

   // Break request and forced reset pulses; FIFO ports take no writes
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         break_q <= 1'b0;
         reset_q <= 1'b0;
      end
      else
      begin
         break_q <= ctl_q[dtr_pkg::BREAK_REQUEST_ENABLE_BIT] && run_done;
         reset_q <= bus.reg_write && bus.background_path
            && bus.reg_index == dtr_pkg::IDX_FORCED_RESET_REQUEST
            && bus.reg_wdata[dtr_pkg::FORCE_RESET_BIT];
      end
   end

   assign bus.reg_rdata = rdata_q;
   assign bus.reg_rvalid = rvalid_q;
   assign break_req = break_q;
   assign break_tag = break_q && ctl_q[dtr_pkg::BREAK_TAG_SELECT_BIT];
   assign mcu_reset_req = reset_q;
   assign capture_run_flag = arm;
endmodule

/* File: rtl/dtr_host.sv */
// Bus-side controller: Avalon-MM registers that drive the register port
`timescale 1ns/1ns
module dtr_host (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Register port
   dtr_if.host port
);
   dtr_pkg::dtr_host_state_t state_q;
   logic [3:0] index_q;
   logic [7:0] wdata_q;
   logic is_write_q;
   logic bg_q;
   logic [7:0] result_q;
   logic rd_ack_q;
   logic [31:0] readdata_q;
   logic cmd_hit;
   logic busy;

   assign busy = state_q != dtr_pkg::DTR_IDLE;
   assign cmd_hit = avs_write && avs_address == dtr_pkg::AV_COMMAND;
   // Commands stall while one is in flight; reads answer one cycle late
   assign avs_waitrequest = (cmd_hit && busy) || (avs_read && !rd_ack_q);

   // Command sequencer; reads of the port wait for valid data
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         state_q <= dtr_pkg::DTR_IDLE;
         index_q <= 4'h0;
         wdata_q <= 8'h00;
         is_write_q <= 1'b0;
         bg_q <= 1'b0;
         result_q <= 8'h00;
      end
      else
      begin
         case (state_q)
            dtr_pkg::DTR_IDLE:
               if (cmd_hit)
               begin
                  wdata_q <= avs_writedata[7:0];
                  index_q <= avs_writedata[dtr_pkg::CMD_INDEX_LSB +: 4];
                  is_write_q <= avs_writedata[dtr_pkg::CMD_WRITE_BIT];
                  bg_q <= avs_writedata[dtr_pkg::CMD_BACKGROUND_BIT];
                  state_q <= dtr_pkg::DTR_ISSUE;
               end
            dtr_pkg::DTR_ISSUE:
               state_q <= is_write_q ? dtr_pkg::DTR_IDLE : dtr_pkg::DTR_WAIT;
            dtr_pkg::DTR_WAIT:
               if (port.reg_rvalid)
               begin
                  result_q <= port.reg_rdata;
                  state_q <= dtr_pkg::DTR_IDLE;
               end
            default: state_q <= dtr_pkg::DTR_IDLE;
         endcase
      end
   end

   // Avalon read data
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         rd_ack_q <= 1'b0;
         readdata_q <= 32'h0000_0000;
      end
      else
      begin
         rd_ack_q <= avs_read && !rd_ack_q;
         if (avs_read && !rd_ack_q)
            readdata_q <= (avs_address == dtr_pkg::AV_STATUS)
               ? {23'h000000, busy, result_q} : 32'h0000_0000;
      end
   end

   assign avs_readdata = readdata_q;
   assign port.reg_index = index_q;
   assign port.reg_wdata = wdata_q;
   assign port.background_path = bg_q;
   assign port.reg_write = state_q == dtr_pkg::DTR_ISSUE && is_write_q;
   assign port.reg_read = state_q == dtr_pkg::DTR_ISSUE && !is_write_q;
endmodule

/* File: bench/dtr_monitor.sv */
// Checker on the register port and device pins between the two ends
`timescale 1ns/1ns
module dtr_monitor (
   // Clock and reset
   input logic ref_clk,
   input logic reset_n,
   // Register port
   input logic [3:0] reg_index,
   input logic [7:0] reg_wdata,
   input logic reg_write,
   input logic reg_read,
   input logic background_path,
   input logic [7:0] reg_rdata,
   input logic reg_rvalid,
   // Device pins
   input logic secure,
   input logic trig_event_only,
   input logic mcu_reset_req,
   input logic capture_run_flag,
   input logic break_req,
   input logic break_tag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence s_bg_force;
      reg_write && reg_index == 4'h0 && background_path && reg_wdata[0];
   endsequence
   sequence s_pulse;
      mcu_reset_req ##1 !mcu_reset_req;
   endsequence
   sequence s_ctl_write;
      reg_write && reg_index == 4'h7;
   endsequence
   property p_answer; reg_read |=> reg_rvalid; endproperty
   a_answer: assert property (p_answer) else $error("read not answered");
   property p_zero; reg_read && reg_index == 4'h0 |=> reg_rdata == 8'h00; endproperty
   a_zero: assert property (p_zero) else $error("reset register read not zero");
   property p_force; s_bg_force |=> s_pulse; endproperty
   a_force: assert property (p_force) else $error("no single reset pulse");
   property p_user; mcu_reset_req |-> $past(background_path && reg_write); endproperty
   a_user: assert property (p_user) else $error("reset without background write");
   property p_arm;
      s_ctl_write ##0 (reg_wdata[7:6] == 2'b11 && !secure && !capture_run_flag)
         |=> capture_run_flag;
   endproperty
   a_arm: assert property (p_arm) else $error("run not started");
   property p_stop; s_ctl_write ##0 !reg_wdata[6] |=> !capture_run_flag; endproperty
   a_stop: assert property (p_stop) else $error("run not stopped");
   property p_secure; s_ctl_write ##0 (secure && !capture_run_flag) |=> !capture_run_flag;
   endproperty
   a_secure: assert property (p_secure) else $error("enabled while secure");
   property p_tag; break_tag |-> break_req; endproperty
   a_tag: assert property (p_tag) else $error("tag without break");
   property p_hi; reg_read && reg_index == 4'h5 && trig_event_only |=> reg_rdata == 8'h00;
   endproperty
   a_hi: assert property (p_hi) else $error("high byte not zero");
endmodule

/* File: bench/tb_top.sv */
// Bench for the bus controller and trace register block joined back to back
`timescale 1ns/1ns
module tb_top;
   logic ref_clk, reset_n, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, r;
   logic cpu_cycle, cpu_read, cpu_fetch, trig_event_only, trig_begin, secure, eqs;
   logic [15:0] cpu_addr, ca, cb, w;
   logic [15:0] a[16];
   logic [7:0] cpu_data, v;
   logic mcu_reset_req, capture_run_flag, break_req, break_tag;
   logic [11:0] e;
   logic [11:0] exp_q[$];
   int bad_count = 0, comparisons = 0, cyc = 0, n_rst = 0, n_brk = 0, n_tag = 0, seed = 79288;
   dtr_if link ();
   dtr_host dtr_host_i (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port(link));
   dtr_device dtr_device_i (.ref_clk(ref_clk), .reset_n(reset_n), .bus(link),
      .cpu_cycle(cpu_cycle), .cpu_addr(cpu_addr), .cpu_read(cpu_read), .cpu_fetch(cpu_fetch),
      .cpu_data(cpu_data), .trig_event_only(trig_event_only), .trig_begin(trig_begin),
      .execution_qualify_select(eqs), .secure(secure), .break_req(break_req),
      .break_tag(break_tag), .mcu_reset_req(mcu_reset_req),
      .capture_run_flag(capture_run_flag));
   dtr_monitor dtr_monitor_i (.ref_clk(ref_clk), .reset_n(reset_n),
      .reg_index(link.reg_index), .reg_wdata(link.reg_wdata), .reg_write(link.reg_write),
      .reg_read(link.reg_read), .background_path(link.background_path),
      .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid), .secure(secure),
      .trig_event_only(trig_event_only), .mcu_reset_req(mcu_reset_req),
      .capture_run_flag(capture_run_flag), .break_req(break_req), .break_tag(break_tag));
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
      comparisons++;
      if (g !== x)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic av(input logic wn, input logic [3:0] ad, input logic [31:0] d);
      @(posedge ref_clk);
      avs_write <= wn;
      avs_read <= !wn;
      avs_address <= ad;
      avs_writedata <= d;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rg(input logic bg, input logic wn, input logic [3:0] ix, input logic [7:0] d);
      av(1'b1, 4'h0, {18'h0, bg, wn, ix, d});
      do av(1'b0, 4'h4, 32'h0); while (r[8] !== 1'b0);
   endtask
   task automatic wr(input logic [3:0] ix, input logic [7:0] d);
      rg(1'b0, 1'b1, ix, d);
   endtask
   task automatic rd(input logic [3:0] ix, input logic [7:0] d);
      exp_q.push_back({ix, d});
      rg(1'b0, 1'b0, ix, 8'h00);
   endtask
   task automatic cp(input logic [15:0] ad, input logic rn, input logic f, input logic [7:0] d);
      @(posedge ref_clk);
      cpu_cycle <= 1'b1;
      cpu_addr <= ad;
      cpu_read <= rn;
      cpu_fetch <= f;
      cpu_data <= d;
      @(posedge ref_clk);
      cpu_cycle <= 1'b0;
      cpu_fetch <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   // Result watcher and timeout
   always @(posedge ref_clk)
   begin
      cyc++;
      if (reset_n === 1'b1 && link.reg_rvalid === 1'b1)
      begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : 12'hfff;
         chk($sformatf("register %0d", e[11:8]), {8'h00, e[7:0]}, {8'h00, link.reg_rdata});
      end
      if (mcu_reset_req === 1'b1)
         n_rst++;
      if (break_req === 1'b1)
      begin
         n_brk++;
         n_tag += int'(break_tag);
      end
      if (cyc == 8000)
      begin
         bad_count++;
         complete_run();
      end
   end
   initial
   begin
      {avs_read, avs_write, cpu_cycle, cpu_read, cpu_fetch, trig_event_only, eqs} = '0;
      {trig_begin, secure, reset_n, avs_address, avs_writedata, cpu_addr, cpu_data} = '0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      foreach (a[i])
         if (i < 5 || i == 7)
            rd(4'(i), 8'h00);
      rd(4'h0, 8'h00);
      $display("test reset values done");
      ca = 16'($random(seed));
      cb = ~ca;
      wr(4'h1, ca[15:8]);
      wr(4'h2, ca[7:0]);
      wr(4'h3, cb[15:8]);
      wr(4'h4, cb[7:0]);
      rd(4'h1, ca[15:8]);
      rd(4'h2, ca[7:0]);
      rd(4'h3, cb[15:8]);
      rd(4'h4, cb[7:0]);
      av(1'b0, 4'h8, 32'h0);
      chk("unmapped", 16'h0000, r[15:0]);
      wr(4'h0, 8'hff);
      rg(1'b1, 1'b1, 4'h0, 8'h01);
      rd(4'h0, 8'h00);
      chk("reset pulses", 16'h0001, n_rst[15:0]);
      $display("test comparators and forced reset done");
      wr(4'h5, 8'($random(seed)));
      wr(4'h6, 8'($random(seed)));
      for (int k = 0; k < 16; k++)
      begin
         a[k] = 16'($random(seed));
         cp(a[k], 1'b1, 1'b1, 8'h00);
         w = k < 8 ? 16'h0000 : a[k - 8];
         rd(4'h5, w[15:8]);
         rd(4'h6, w[7:0]);
      end
      $display("test profiling done");
      v = 8'($random(seed)) & 8'h3f;
      wr(4'h7, v);
      rd(4'h7, v);
      secure <= 1'b1;
      wr(4'h7, v | 8'hc0);
      rd(4'h7, v);
      secure <= 1'b0;
      wr(4'h7, 8'hdc);
      chk("run flag", 16'h0001, {15'h0, capture_run_flag});
      wr(4'h1, ~ca[15:8]);
      rd(4'h1, ca[15:8]);
      rd(4'h7, 8'hdc);
      cp(ca, 1'b0, 1'b0, 8'h00);
      chk("breaks", 16'h0000, n_brk[15:0]);
      cp(ca, 1'b1, 1'b0, 8'h00);
      chk("breaks", 16'h0001, n_brk[15:0]);
      chk("tags", 16'h0000, n_tag[15:0]);
      chk("run flag", 16'h0000, {15'h0, capture_run_flag});
      wr(4'h7, 8'h00);
      wr(4'h7, 8'hf0);
      eqs <= 1'b1;
      cp(cb, 1'b0, 1'b1, 8'h00);
      chk("breaks", 16'h0002, n_brk[15:0]);
      chk("tags", 16'h0001, n_tag[15:0]);
      $display("test end trace done");
      wr(4'h7, 8'h00);
      wr(4'h7, 8'hc0);
      chk("run flag", 16'h0001, {15'h0, capture_run_flag});
      wr(4'h7, 8'h80);
      chk("run flag", 16'h0000, {15'h0, capture_run_flag});
      trig_event_only <= 1'b1;
      trig_begin <= 1'b1;
      wr(4'h7, 8'hc0);
      rd(4'h6, a[9][7:0]);
      rd(4'h6, a[9][7:0]);
      for (int k = 0; k < 8; k++)
      begin
         a[k] = 16'($random(seed));
         cp(cb, 1'b1, 1'b0, a[k][7:0]);
      end
      chk("run flag", 16'h0000, {15'h0, capture_run_flag});
      rd(4'h5, 8'h00);
      for (int k = 0; k < 8; k++)
         rd(4'h6, a[k][7:0]);
      chk("breaks", 16'h0002, n_brk[15:0]);
      $display("test event only done");
      complete_run();
   end
endmodule
